// *** verilog/fsg_access_guard.sv ***
// Access guard for flash self-programming: locks, stalls, addressing.
// Assumes a core that holds store and load requests for one cycle each,
// and a flash macro that pulses flash_done_i when an erase or write ends.
`timescale 1ns/10ps
`include "fsg_regs.svh"

module fsg_access_guard import fsg_pkg::*; #(
    parameter int PAGE_WORD_BITS = 6,
    parameter int LOADER_START_PAGE = 480,
    parameter int HALT_START_PAGE = 448
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Core execution state
    input wire logic [`FSG_PTR_W-2:0] pc_i,
    input wire logic vectors_in_loader_i,
    // Store requests
    input wire logic store_valid_i,
    input wire fsg_store_req_t store_req_i,
    output logic store_refused_o,
    // Load requests
    input wire logic load_valid_i,
    input wire logic [`FSG_PTR_W-1:0] load_ptr_i,
    output logic load_valid_o,
    output logic load_refused_o,
    output logic [7:0] load_data_o,
    // Busy flag clear from software
    input wire logic busy_clear_i,
    output logic concurrent_section_busy_flag_o,
    // Core control
    output logic cpu_stall_o,
    output logic fetch_ok_o,
    output logic irq_disable_o,
    output logic [`FSG_PTR_W-2:0] reset_addr_o,
    // Fuses and programming interface
    input wire logic reset_vector_select_fuse_i,
    input wire fsg_lock_t lock_nv_i,
    input wire logic pgm_lock_we_i,
    input wire fsg_lock_t pgm_lock_i,
    input wire logic chip_erase_i,
    output fsg_lock_t lock_o,
    // Flash macro
    output logic [`FSG_PTR_W-2:0] flash_raddr_o,
    input wire logic [15:0] flash_rdata_i,
    output logic flash_erase_o,
    output logic flash_write_o,
    output logic [`FSG_PTR_W-2-PAGE_WORD_BITS:0] flash_page_o,
    input wire logic flash_done_i,
    output logic buf_we_o,
    output logic [PAGE_WORD_BITS-1:0] buf_word_o,
    output logic [15:0] buf_data_o
);

    localparam int PAGE_W = `FSG_PTR_W - 1 - PAGE_WORD_BITS;
    localparam logic [PAGE_W-1:0] LDR_PG = PAGE_W'(LOADER_START_PAGE);
    localparam logic [PAGE_W-1:0] HALT_PG = PAGE_W'(HALT_START_PAGE);
    localparam logic [`FSG_PTR_W-2:0] LDR_RESET_ADDR =
        {LDR_PG, {PAGE_WORD_BITS{1'b0}}};

    typedef enum logic {FSG_IDLE, FSG_PROG} fsg_state_t;

    logic rst_n;
    fsg_state_t st_r;
    fsg_state_t st_nxt;
    fsg_lock_t lock_r;
    logic init_done_r;
    logic halt_r;
    logic busy_r;
    logic [PAGE_W-1:0] page_r;

    fsg_rst_sync u_rst_sync (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .rstn_o(rst_n)
    );

    // Section of the running code and of each target
    wire [PAGE_W-1:0] exec_page = pc_i[`FSG_PTR_W-2:PAGE_WORD_BITS];
    wire exec_in_loader = exec_page >= LDR_PG;
    wire [PAGE_W-1:0] st_page = store_req_i.ptr[`FSG_PTR_W-1:PAGE_WORD_BITS+1];
    wire [PAGE_WORD_BITS-1:0] st_word = store_req_i.ptr[PAGE_WORD_BITS:1];
    wire st_tgt_loader = st_page >= LDR_PG;
    wire st_tgt_halt = st_page >= HALT_PG;
    wire [PAGE_W-1:0] ld_page = load_ptr_i[`FSG_PTR_W-1:PAGE_WORD_BITS+1];
    wire ld_tgt_loader = ld_page >= LDR_PG;
    wire ld_tgt_halt = ld_page >= HALT_PG;
    wire fetch_in_halt = exec_page >= HALT_PG;

    // Section lock decoders
    logic app_store_block;
    logic app_load_block;
    logic ldr_store_block;
    logic ldr_load_block;

    fsg_lock_dec u_app_dec (
        .upper_i(lock_r.app_lock_upper),
        .lower_i(lock_r.app_lock_lower),
        .store_block_o(app_store_block),
        .load_block_o(app_load_block)
    );

    fsg_lock_dec u_ldr_dec (
        .upper_i(lock_r.loader_lock_upper),
        .lower_i(lock_r.loader_lock_lower),
        .store_block_o(ldr_store_block),
        .load_block_o(ldr_load_block)
    );

    // Store acceptance; general lock bits play no part
    wire is_prog = (store_req_i.op == FSG_OP_ERASE) || (store_req_i.op == FSG_OP_WRITE);
    wire st_wr_blocked = st_tgt_loader ? ldr_store_block : app_store_block;
    wire store_ok = store_valid_i && exec_in_loader && (st_r == FSG_IDLE)
        && !(is_prog && st_wr_blocked);
    wire start_prog = store_ok && is_prog;
    wire start_lock = store_ok && (store_req_i.op == FSG_OP_LOCKSET);
    wire start_fill = store_ok && (store_req_i.op == FSG_OP_FILL);

    // Load acceptance: cross-section reads under lock, blocked sections
    wire ld_lock_blk = exec_in_loader ? (!ld_tgt_loader && app_load_block)
        : (ld_tgt_loader && ldr_load_block);
    wire ld_sect_blk = cpu_stall_o || (busy_r && !ld_tgt_halt);
    wire load_ok = load_valid_i && !ld_lock_blk && !ld_sect_blk;

    // Core-facing combinational controls
    assign cpu_stall_o = (st_r == FSG_PROG) && halt_r;
    assign fetch_ok_o = !cpu_stall_o && !(busy_r && !fetch_in_halt);
    assign irq_disable_o = (vectors_in_loader_i && !exec_in_loader && app_load_block)
        || (!vectors_in_loader_i && exec_in_loader && ldr_load_block);
    assign flash_raddr_o = load_ptr_i[`FSG_PTR_W-1:1];
    assign concurrent_section_busy_flag_o = busy_r;
    assign lock_o = lock_r;
    assign flash_page_o = page_r;

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            FSG_IDLE: begin
                if (start_prog) begin
                    st_nxt = FSG_PROG;
                end
            end
            FSG_PROG: begin
                if (flash_done_i) begin
                    st_nxt = FSG_IDLE;
                end
            end
        endcase
    end

    // Sequencer state and latched page
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= FSG_IDLE;
            page_r <= '0;
            halt_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (start_prog) begin
                page_r <= st_page;
                halt_r <= st_tgt_halt;
            end
        end
    end

    // Flash command pulses
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
        end else begin
            flash_erase_o <= start_prog && (store_req_i.op == FSG_OP_ERASE);
            flash_write_o <= start_prog && (store_req_i.op == FSG_OP_WRITE);
        end
    end

    // Busy flag: a new concurrent-section start beats a software clear
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (start_prog && !st_tgt_halt) begin
            busy_r <= 1'b1;
        end else if (busy_clear_i && (st_r == FSG_IDLE)) begin
            busy_r <= 1'b0;
        end
    end

    // Temporary buffer write port
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            buf_we_o <= 1'b0;
            buf_word_o <= '0;
            buf_data_o <= 16'h0000;
        end else begin
            buf_we_o <= start_fill;
            if (start_fill) begin
                buf_word_o <= st_word;
                buf_data_o <= store_req_i.data;
            end
        end
    end

    // Lock bits: load image after reset, then only program or chip erase
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lock_r <= `FSG_LOCK_ERASED;
            init_done_r <= 1'b0;
        end else begin
            init_done_r <= 1'b1;
            if (!init_done_r) begin
                lock_r <= lock_nv_i;
            end else if (chip_erase_i) begin
                lock_r <= `FSG_LOCK_ERASED;
            end else if (pgm_lock_we_i) begin
                lock_r <= lock_r & pgm_lock_i;
            end else if (start_lock) begin
                lock_r <= lock_r & store_req_i.data[`FSG_LOCK_W-1:0];
            end
        end
    end

    // Reset vector follows the fuse input; no software path reaches it
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reset_addr_o <= `FSG_APP_RESET_ADDR;
        end else begin
            reset_addr_o <= reset_vector_select_fuse_i ? `FSG_APP_RESET_ADDR
                : LDR_RESET_ADDR;
        end
    end

    // Load and store answers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            load_valid_o <= 1'b0;
            load_refused_o <= 1'b0;
            load_data_o <= 8'h00;
            store_refused_o <= 1'b0;
        end else begin
            load_valid_o <= load_ok;
            load_refused_o <= load_valid_i && !load_ok;
            store_refused_o <= store_valid_i && !store_ok;
            if (load_ok) begin
                load_data_o <= load_ptr_i[0] ? flash_rdata_i[15:8] : flash_rdata_i[7:0];
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_halt_start;
        start_prog && st_tgt_halt;
    endsequence

    sequence s_stall_hold;
        cpu_stall_o && !fetch_ok_o;
    endsequence

    a_halt_stall: assert property (s_halt_start |=> s_stall_hold [*1] ##0 (flash_erase_o || flash_write_o))
        else $error("halting section operation did not stall");
    a_crs_no_stall: assert property (start_prog && !st_tgt_halt |=> !cpu_stall_o && busy_r)
        else $error("concurrent section operation stalled core");
    a_busy_holds: assert property (busy_r && !busy_clear_i |=> busy_r)
        else $error("busy flag dropped without clear");
    a_app_store_lock: assert property (store_valid_i && is_prog && !st_tgt_loader
        && !lock_r.app_lock_lower |=> !flash_erase_o && !flash_write_o && store_refused_o)
        else $error("locked application store started");
    a_ldr_store_lock: assert property (store_valid_i && is_prog && st_tgt_loader
        && !lock_r.loader_lock_lower |=> !flash_erase_o && !flash_write_o)
        else $error("locked loader store started");
    a_app_exec_store: assert property (store_valid_i && !exec_in_loader && init_done_r
        && !chip_erase_i && !pgm_lock_we_i |=> store_refused_o && !buf_we_o && $stable(lock_r))
        else $error("store from application section acted");
    a_lock_cross_load: assert property (load_valid_i && exec_in_loader && !ld_tgt_loader
        && !lock_r.app_lock_upper |=> load_refused_o && !load_valid_o)
        else $error("cross-section load passed under lock");
    a_ldr_cross_load: assert property (load_valid_i && !exec_in_loader && ld_tgt_loader
        && !lock_r.loader_lock_upper |=> load_refused_o)
        else $error("loader load passed under lock");
    a_page_latched: assert property (start_prog |=> (flash_page_o == $past(st_page))
        ##1 $stable(flash_page_o))
        else $error("page not latched at start");
    a_lock_no_clear: assert property (init_done_r && !chip_erase_i |=> (lock_r & ~$past(lock_r))
        == '0)
        else $error("lock bit cleared without chip erase");
    // Only once the vector flop has left reset does it mirror last cycle's fuse
    a_reset_vector: assert property (init_done_r |-> reset_addr_o ==
        ($past(reset_vector_select_fuse_i) ? `FSG_APP_RESET_ADDR : LDR_RESET_ADDR))
        else $error("reset vector does not follow fuse");

endmodule // fsg_access_guard

// *** verilog/fsg_regs.svh ***
// Constants for the flash self-program access guard.
// Assumes a 16-bit byte pointer and 16-bit flash words.
//
// What this block does
// - Concurrent-section erase or write keeps halting section readable, no stall.
// - Halting-section erase or write stalls the core; nothing is readable meanwhile.
// - Lock bits programmed by software or programming port; cleared only by chip erase.
// - General write lock does not block self-programming stores.
// - General read/write lock does not restrict core loads or stores.
// - Application lock: 11 free, 10 and 00 block stores to application section.
// - Application lock 00 or 01 refuses loads from loader code into application.
// - In those modes, vectors in loader: interrupts off while running application.
// - Loader lock: 11 free, 10 and 00 block stores to loader section.
// - Loader lock 00 or 01 refuses loads from application code into loader.
// - In those modes, vectors in application: interrupts off while running loader.
// - Reset vector is 0x0000 when fuse is 1, loader reset address when 0.
// - Software cannot alter fuses; only the programming interface can.
// - Store pointer low bits pick word in page, high bits pick page.
// - Pointer address is latched when a programming operation starts.
// - Lock-setting store ignores the pointer entirely.
// - Loads address bytes; pointer bit 0 picks low or high byte.
// - Busy flag stays one while concurrent section is blocked, until software clears.
// - Stores start programming only when executed from the loader section.
`ifndef FSG_REGS_SVH
`define FSG_REGS_SVH

`define FSG_PTR_W 16
`define FSG_LOCK_W 6
`define FSG_LOCK_ERASED 6'h3f
`define FSG_APP_RESET_ADDR 15'h0000

`endif

// *** verilog/fsg_pkg.sv ***
// Types shared by the access guard and its helpers.
// Assumes fsg_regs.svh supplies the widths.
`include "fsg_regs.svh"

package fsg_pkg;

    // Kinds of program-memory store
    typedef enum logic [1:0] {
        FSG_OP_FILL,
        FSG_OP_ERASE,
        FSG_OP_WRITE,
        FSG_OP_LOCKSET
    } fsg_store_op_t;

    // One store request from the core
    typedef struct packed {
        fsg_store_op_t op;
        logic [`FSG_PTR_W-1:0] ptr;
        logic [15:0] data;
    } fsg_store_req_t;

    // Lock bits in the order the lock-set data carries them
    typedef struct packed {
        logic loader_lock_upper;
        logic loader_lock_lower;
        logic app_lock_upper;
        logic app_lock_lower;
        logic [1:0] general_lock;
    } fsg_lock_t;

endpackage

// *** verilog/fsg_rst_sync.sv ***
// Reset release synchroniser.
// Assumes an active-low asynchronous reset input.
`timescale 1ns/10ps

module fsg_rst_sync (
    // Clock and raw reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Synchronised reset
    output logic rstn_o
);

    logic meta_r;
    logic hold_r;

    // Assert at once, release after two edges
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            hold_r <= meta_r;
        end
    end

    assign rstn_o = hold_r;

endmodule // fsg_rst_sync

// *** verilog/fsg_lock_dec.sv ***
// Decoder for one two-bit section lock field.
// Assumes 1 means unprogrammed for both bits.
`timescale 1ns/10ps

module fsg_lock_dec (
    // Lock field
    input wire logic upper_i,
    input wire logic lower_i,
    // Decoded restrictions
    output logic store_block_o,
    output logic load_block_o
);

    // Modes 10 and 00 block stores; 00 and 01 block cross-section loads
    assign store_block_o = ~lower_i;
    assign load_block_o = ~upper_i;

endmodule // fsg_lock_dec

// *** sim/fsg_flash_model.sv ***
// Behavioural flash macro facing the access guard.
// Assumes one-cycle start pulses and a single clock domain.
`timescale 1ns/10ps

module fsg_flash_model #(
    parameter int BUSY_CYCLES = 5
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Read port
    input wire logic [14:0] raddr_i,
    output logic [15:0] rdata_o,
    // Program control
    input wire logic start_i,
    output logic done_o
);
    logic [7:0] cnt_r;

    // Low byte is the word address, high byte its inverse, so byte lanes differ
    assign rdata_o = {~raddr_i[7:0], raddr_i[7:0]};
    assign done_o = (cnt_r == 8'h01);

    // Counts from a start pulse down to the single done pulse
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 8'h00;
        end else if (start_i) begin
            cnt_r <= BUSY_CYCLES[7:0];
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule // fsg_flash_model

// *** sim/fsg_access_guard_tb_top.sv ***
// Self-checking bench for the flash self-program access guard.
// Assumes the flash model answers reads at once and ends operations after a few cycles.
`timescale 1ns/10ps
`include "fsg_regs.svh"

module fsg_access_guard_tb_top import fsg_pkg::*;;
    localparam int PWB = 6;
    localparam int LSP = 480;
    localparam int HSP = 448;
    localparam logic [14:0] LP = 15'(LSP << PWB);
    localparam logic [14:0] HP = 15'(HSP << PWB);
    localparam logic [14:0] AP = 15'h0000;
    logic core_clk_i = 1'b0, rstn_i = 1'b0, vectors_in_loader_i = 1'b0;
    logic store_valid_i = 1'b0, load_valid_i = 1'b0, busy_clear_i = 1'b0;
    logic reset_vector_select_fuse_i = 1'b1, pgm_lock_we_i = 1'b0, chip_erase_i = 1'b0;
    logic [14:0] pc_i = 15'h0000;
    logic [15:0] load_ptr_i = 16'h0000;
    fsg_store_req_t store_req_i = '0;
    fsg_lock_t lock_nv_i = 6'h3f, pgm_lock_i = 6'h3f, lock_o;
    logic store_refused_o, load_valid_o, load_refused_o, concurrent_section_busy_flag_o;
    logic cpu_stall_o, fetch_ok_o, irq_disable_o, flash_erase_o, flash_write_o;
    logic flash_done_i, buf_we_o;
    logic [7:0] load_data_o;
    logic [14:0] reset_addr_o, flash_raddr_o;
    logic [15:0] flash_rdata_i, buf_data_o;
    logic [8:0] flash_page_o;
    logic [5:0] buf_word_o;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;

    fsg_access_guard #(.PAGE_WORD_BITS(PWB), .LOADER_START_PAGE(LSP), .HALT_START_PAGE(HSP)) dut (
        .core_clk_i, .rstn_i, .pc_i, .vectors_in_loader_i, .store_valid_i, .store_req_i,
        .store_refused_o, .load_valid_i, .load_ptr_i, .load_valid_o, .load_refused_o,
        .load_data_o, .busy_clear_i, .concurrent_section_busy_flag_o, .cpu_stall_o,
        .fetch_ok_o, .irq_disable_o, .reset_addr_o, .reset_vector_select_fuse_i, .lock_nv_i,
        .pgm_lock_we_i, .pgm_lock_i, .chip_erase_i, .lock_o, .flash_raddr_o, .flash_rdata_i,
        .flash_erase_o, .flash_write_o, .flash_page_o, .flash_done_i, .buf_we_o, .buf_word_o,
        .buf_data_o);

    // Long enough that the refused store and the fetch_halt check fall inside the operation
    fsg_flash_model #(.BUSY_CYCLES(8)) flash (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .raddr_i(flash_raddr_o), .rdata_o(flash_rdata_i),
        .start_i(flash_erase_o | flash_write_o), .done_o(flash_done_i));

    // Clock and hang guard
    always #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Holds reset three cycles, then waits out the release and lock load
    task automatic rst(input logic fuse);
        @(posedge core_clk_i);
        rstn_i <= 1'b0;
        reset_vector_select_fuse_i <= fuse;
        repeat (3) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask

    // One store pulse; answers are sampled in the following cycle
    task automatic st(input logic [14:0] pc, input fsg_store_op_t o, input logic [15:0] p,
                      input logic [15:0] d);
        @(posedge core_clk_i);
        pc_i <= pc;
        store_valid_i <= 1'b1;
        store_req_i <= '{o, p, d};
        @(posedge core_clk_i);
        store_valid_i <= 1'b0;
        #1;
    endtask

    task automatic ld(input logic [14:0] pc, input logic [15:0] p);
        @(posedge core_clk_i);
        pc_i <= pc;
        load_valid_i <= 1'b1;
        load_ptr_i <= p;
        @(posedge core_clk_i);
        load_valid_i <= 1'b0;
        #1;
    endtask

    // Chip erase, then program locks through the programming port
    task automatic pl(input logic [5:0] lk);
        @(posedge core_clk_i);
        chip_erase_i <= 1'b1;
        @(posedge core_clk_i);
        chip_erase_i <= 1'b0;
        pgm_lock_we_i <= 1'b1;
        pgm_lock_i <= lk;
        @(posedge core_clk_i);
        pgm_lock_we_i <= 1'b0;
        #1;
        chk("lock", lock_o, lk);
    endtask

    task automatic wd();
        int n = 0;
        while (flash_done_i !== 1'b1 && n < 50) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk("flash_done", flash_done_i, 16'h0001);
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic clr();
        @(posedge core_clk_i);
        busy_clear_i <= 1'b1;
        @(posedge core_clk_i);
        busy_clear_i <= 1'b0;
        #1;
    endtask

    // Main sequence
    initial begin
        logic [1:0] codes [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
        logic [1:0] c;
        rst(1'b1);
        chk("reset_addr", reset_addr_o, 16'h0000);
        pl(6'h3c);
        st(LP, FSG_OP_FILL, 16'h0043, 16'h1234);
        chk("buf_we", buf_we_o, 16'h0001);
        chk("buf_word", buf_word_o, 16'h0021);
        chk("buf_data", buf_data_o, 16'h1234);
        st(AP, FSG_OP_ERASE, 16'h0280, 16'h0000);
        chk("refused_app", store_refused_o, 16'h0001);
        chk("erase_app", flash_erase_o, 16'h0000);
        st(LP, FSG_OP_ERASE, 16'h02be, 16'h0000);
        chk("erase", flash_erase_o, 16'h0001);
        chk("page", flash_page_o, 16'h0005);
        chk("stall_cc", cpu_stall_o, 16'h0000);
        chk("busy_set", concurrent_section_busy_flag_o, 16'h0001);
        ld(HP, 16'he101);
        chk("ld_halt", load_valid_o, 16'h0001);
        chk("ld_hi", load_data_o, 16'h007f);
        chk("fetch_halt", fetch_ok_o, 16'h0001);
        ld(HP, 16'h0280);
        chk("ld_cc_busy", load_refused_o, 16'h0001);
        st(LP, FSG_OP_WRITE, 16'h0300, 16'h0000);
        chk("st_busy", store_refused_o, 16'h0001);
        wd();
        chk("page_held", flash_page_o, 16'h0005);
        chk("busy_hold", concurrent_section_busy_flag_o, 16'h0001);
        // Fetch from the concurrent section stays blocked until software clears
        @(posedge core_clk_i);
        pc_i <= AP;
        #1;
        chk("fetch_cc_busy", fetch_ok_o, 16'h0000);
        clr();
        chk("busy_clr", concurrent_section_busy_flag_o, 16'h0000);
        ld(HP, 16'h0280);
        chk("ld_lo", load_data_o, 16'h0040);
        st(LP, FSG_OP_ERASE, 16'he600, 16'h0000);
        chk("stall", cpu_stall_o, 16'h0001);
        chk("fetch_none", fetch_ok_o, 16'h0000);
        ld(LP, 16'he101);
        chk("ld_stall", load_refused_o, 16'h0001);
        wd();
        chk("stall_end", cpu_stall_o, 16'h0000);
        st(LP, FSG_OP_WRITE, 16'he600, 16'h0000);
        chk("write", flash_write_o, 16'h0001);
        chk("wpage", flash_page_o, 16'h01cc);
        wd();
        st(LP, FSG_OP_LOCKSET, 16'hffff, 16'h00fb);
        chk("lockset", lock_o, 16'h0038);
        chk("ls_erase", flash_erase_o, 16'h0000);
        // Every code of each section lock field
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                c = codes[i];
                pl((k == 1) ? {c, 4'hf} : {2'h3, c, 2'h3});
                st(LP, FSG_OP_ERASE, (k == 1) ? 16'hf500 : 16'h0280, 16'h0000);
                chk("lk_store", store_refused_o, {15'h0000, ~c[0]});
                if (c[0]) begin
                    wd();
                    clr();
                end
                ld((k == 1) ? AP : LP, (k == 1) ? 16'hf500 : 16'h0280);
                chk("lk_load", load_refused_o, {15'h0000, ~c[1]});
                @(posedge core_clk_i);
                pc_i <= (k == 1) ? LP : AP;
                vectors_in_loader_i <= (k == 0);
                #1;
                chk("irq_off", irq_disable_o, {15'h0000, ~c[1]});
            end
        end
        rst(1'b0);
        chk("reset_ldr", reset_addr_o, {1'b0, LP});
        summarize();
    end
endmodule // fsg_access_guard_tb_top
